//--- src/rph_pkg.sv
// package: register map, reset values, field positions, state types for the packet handler
package rph_pkg;

  // register offsets on the register port
  localparam logic [5:0] OFS_FIFO_THR = 6'h03;
  localparam logic [5:0] OFS_MARK_HI = 6'h04;
  localparam logic [5:0] OFS_MARK_LO = 6'h05;
  localparam logic [5:0] OFS_LEN_LIM = 6'h06;
  localparam logic [5:0] OFS_CTRL_A = 6'h07;
  localparam logic [5:0] OFS_CTRL_B = 6'h08;
  localparam logic [5:0] OFS_NODE_ID = 6'h09;

  // reset values
  localparam logic [7:0] RST_FIFO_THR = 8'h07;
  localparam logic [7:0] RST_MARK_HI = 8'hD3;
  localparam logic [7:0] RST_MARK_LO = 8'h91;
  localparam logic [7:0] RST_LEN_LIM = 8'hFF;
  localparam logic [7:0] RST_CTRL_A = 8'h04;
  localparam logic [7:0] RST_CTRL_B = 8'h45;
  localparam logic [7:0] RST_NODE_ID = 8'h00;

  // writable bits; unused bits read as zero
  localparam logic [7:0] WMASK_CTRL_A = 8'hEF;
  localparam logic [7:0] WMASK_CTRL_B = 8'h77;

  // field positions in control register a
  localparam int CA_FLUSH_BIT = 3;
  localparam int CA_APPEND_BIT = 2;
  localparam int CA_FILT_LSB = 0;
  // field positions in control register b
  localparam int CB_FMT_LSB = 4;
  localparam int CB_CRC_BIT = 2;
  localparam int CB_LEN_LSB = 0;

  // field encodings
  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [1:0] FILT_OWN = 2'h1;
  localparam logic [1:0] FILT_BC00 = 2'h2;
  localparam logic [1:0] FILT_BCFF = 2'h3;
  localparam logic [1:0] FMT_FIFO = 2'h0;
  localparam logic [1:0] FMT_SYNC = 2'h1;
  localparam logic [1:0] FMT_ASYNC = 2'h3;
  localparam logic [1:0] LEN_FIXED = 2'h0;
  localparam logic [1:0] LEN_VAR = 2'h1;
  localparam logic [1:0] LEN_INF = 2'h2;
  localparam logic [7:0] BCAST_LOW = 8'h00;
  localparam logic [7:0] BCAST_HIGH = 8'hFF;

  // check sequence and receive buffer
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam int FIFO_AW = 6;

  typedef enum logic [2:0] {TX_IDLE, TX_MARK_LO, TX_LEN, TX_PAY, TX_CRC_HI, TX_CRC_LO,
    TX_INF} rph_tx_e;
  typedef enum logic [3:0] {RX_HUNT, RX_MARK_LO, RX_LEN, RX_PAY, RX_CRC_HI, RX_CRC_LO,
    RX_STAT_A, RX_STAT_B, RX_INF} rph_rx_e;

  // software-visible settings
  typedef struct packed {
    logic [7:0] fifo_thr;
    logic [7:0] mark_hi;
    logic [7:0] mark_lo;
    logic [7:0] len_lim;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] node_id;
  } rph_regs_s;

  // state of the packet handler apart from the receive buffer storage
  typedef struct packed {
    rph_regs_s regs;
    logic [7:0] reg_rdata;
    rph_tx_e tx_state;
    logic [7:0] tx_cnt;
    logic [7:0] tx_len;
    logic [15:0] tx_crc;
    logic tx_ready;
    logic air_tx_valid;
    logic [7:0] air_tx_byte;
    logic tx_done;
    rph_rx_e rx_state;
    logic [7:0] rx_cnt;
    logic [7:0] rx_len;
    logic [15:0] rx_crc;
    logic rx_crc_ok;
    logic [FIFO_AW:0] wr_ptr;
    logic [FIFO_AW:0] rd_ptr;
    logic [FIFO_AW:0] pkt_start;
    logic [FIFO_AW:0] rx_count;
    logic pkt_ok;
    logic pkt_bad;
    logic air_serial_tx;
    logic general_output_pins;
  } rph_state_s;

  // one byte through the check-sequence generator, msb first
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ data[i]) begin
        c = {c[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

endpackage

//--- src/rph_rx_mem.sv
// receive buffer storage with registered read data
`timescale 1ns/10ps
module rph_rx_mem (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [rph_pkg::FIFO_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  input wire logic [rph_pkg::FIFO_AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:(1<<rph_pkg::FIFO_AW)-1];

  // storage write, no reset on the array itself
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read port, data held until the next read
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // rph_rx_mem

//--- src/rph_packet_handler.sv
// packet handler: marker word, length modes, node filter, check sequence, serial paths
// Operation
// - marker word is high byte then low byte
// - marker bytes reset to D3 and 91
// - fixed mode: length register is exact length
// - variable mode: length register is maximum accepted
// - flush option drops packets failing check
// - append option adds signal strength status bytes
// - filter select: none, own, plus broadcasts
// - format selects buffered, synchronous or asynchronous
// - serial: data in pin zero, out pin
// - length select: fixed, variable, unlimited, reserved
// - unlimited mode runs until setting changes
// - filter compares address with node identifier
// - broadcasts 00 and FF only when enabled
`timescale 1ns/10ps
module rph_packet_handler (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic tx_done,
  output logic [7:0] air_tx_byte,
  output logic air_tx_valid,
  input wire logic air_tx_ready,
  input wire logic [7:0] air_rx_byte,
  input wire logic air_rx_valid,
  input wire logic [7:0] rssi,
  input wire logic rx_pop,
  output logic [7:0] rx_data,
  output logic [6:0] rx_count,
  output logic pkt_ok,
  output logic pkt_bad,
  input wire logic general_pin_zero,
  input wire logic air_serial_rx,
  input wire logic serial_bit_strobe,
  output logic air_serial_tx,
  output logic general_output_pins
);
  rph_pkg::rph_state_s s_reg;
  rph_pkg::rph_state_s s_next;
  logic mem_we;
  logic [rph_pkg::FIFO_AW-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic mem_re;

  // decoded settings
  logic flush_en;
  logic append_en;
  logic [1:0] filt_sel;
  logic [1:0] fmt;
  logic crc_en;
  logic [1:0] len_cfg;
  assign flush_en = s_reg.regs.ctrl_a[rph_pkg::CA_FLUSH_BIT];
  assign append_en = s_reg.regs.ctrl_a[rph_pkg::CA_APPEND_BIT];
  assign filt_sel = s_reg.regs.ctrl_a[rph_pkg::CA_FILT_LSB +: 2];
  assign fmt = s_reg.regs.ctrl_b[rph_pkg::CB_FMT_LSB +: 2];
  assign crc_en = s_reg.regs.ctrl_b[rph_pkg::CB_CRC_BIT];
  assign len_cfg = s_reg.regs.ctrl_b[rph_pkg::CB_LEN_LSB +: 2];

  // receive buffer storage
  rph_rx_mem u_mem (
    .core_clk(core_clk),
    .srst(srst),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_en(mem_re),
    .rd_addr(s_reg.rd_ptr[rph_pkg::FIFO_AW-1:0]),
    .rd_data(rx_data)
  );

  // next-state logic for registers, transmit, receive and serial paths
  always_comb begin
    logic can_emit;
    logic take;
    logic full;
    logic addr_ok;
    logic finish;
    logic [15:0] crc_new;
    can_emit = 1'b0;
    take = 1'b0;
    full = 1'b0;
    addr_ok = 1'b0;
    finish = 1'b0;
    crc_new = 16'h0000;
    s_next = s_reg;
    mem_we = 1'b0;
    mem_waddr = s_reg.wr_ptr[rph_pkg::FIFO_AW-1:0];
    mem_wdata = air_rx_byte;
    mem_re = 1'b0;
    s_next.tx_done = 1'b0;
    s_next.pkt_ok = 1'b0;
    s_next.pkt_bad = 1'b0;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        rph_pkg::OFS_FIFO_THR: s_next.regs.fifo_thr = reg_wdata;
        rph_pkg::OFS_MARK_HI: s_next.regs.mark_hi = reg_wdata;
        rph_pkg::OFS_MARK_LO: s_next.regs.mark_lo = reg_wdata;
        rph_pkg::OFS_LEN_LIM: s_next.regs.len_lim = reg_wdata;
        rph_pkg::OFS_CTRL_A: s_next.regs.ctrl_a = reg_wdata & rph_pkg::WMASK_CTRL_A;
        rph_pkg::OFS_CTRL_B: s_next.regs.ctrl_b = reg_wdata & rph_pkg::WMASK_CTRL_B;
        rph_pkg::OFS_NODE_ID: s_next.regs.node_id = reg_wdata;
        default: ;
      endcase
    end
    // register reads, unmapped offsets read zero
    if (reg_rd) begin
      case (reg_addr)
        rph_pkg::OFS_FIFO_THR: s_next.reg_rdata = s_reg.regs.fifo_thr;
        rph_pkg::OFS_MARK_HI: s_next.reg_rdata = s_reg.regs.mark_hi;
        rph_pkg::OFS_MARK_LO: s_next.reg_rdata = s_reg.regs.mark_lo;
        rph_pkg::OFS_LEN_LIM: s_next.reg_rdata = s_reg.regs.len_lim;
        rph_pkg::OFS_CTRL_A: s_next.reg_rdata = s_reg.regs.ctrl_a;
        rph_pkg::OFS_CTRL_B: s_next.reg_rdata = s_reg.regs.ctrl_b;
        rph_pkg::OFS_NODE_ID: s_next.reg_rdata = s_reg.regs.node_id;
        default: s_next.reg_rdata = 8'h00;
      endcase
    end

    // transmit framer; output byte slot drains when the modulator takes it
    can_emit = !s_reg.air_tx_valid || air_tx_ready;
    if (s_reg.air_tx_valid && air_tx_ready) begin
      s_next.air_tx_valid = 1'b0;
    end
    take = tx_valid && s_reg.tx_ready;
    case (s_reg.tx_state)
      rph_pkg::TX_IDLE: begin
        if (tx_valid && fmt == rph_pkg::FMT_FIFO && can_emit) begin
          s_next.air_tx_valid = 1'b1;
          s_next.air_tx_byte = s_reg.regs.mark_hi;
          s_next.tx_crc = rph_pkg::CRC_INIT;
          s_next.tx_state = rph_pkg::TX_MARK_LO;
        end
      end
      rph_pkg::TX_MARK_LO: begin
        if (can_emit) begin
          s_next.air_tx_valid = 1'b1;
          s_next.air_tx_byte = s_reg.regs.mark_lo;
          s_next.tx_cnt = 8'h00;
          s_next.tx_len = s_reg.regs.len_lim;
          if (len_cfg == rph_pkg::LEN_FIXED) begin
            s_next.tx_state = rph_pkg::TX_PAY;
          end else if (len_cfg == rph_pkg::LEN_INF) begin
            s_next.tx_state = rph_pkg::TX_INF;
          end else begin
            s_next.tx_state = rph_pkg::TX_LEN;
          end
        end
      end
      rph_pkg::TX_LEN: begin
        if (take) begin
          s_next.air_tx_valid = 1'b1;
          s_next.air_tx_byte = tx_byte;
          s_next.tx_len = tx_byte;
          s_next.tx_crc = rph_pkg::crc_step(s_reg.tx_crc, tx_byte);
          if (tx_byte == 8'h00) begin
            s_next.tx_state = crc_en ? rph_pkg::TX_CRC_HI : rph_pkg::TX_IDLE;
            s_next.tx_done = !crc_en;
          end else begin
            s_next.tx_state = rph_pkg::TX_PAY;
          end
        end
      end
      rph_pkg::TX_PAY: begin
        if (take) begin
          s_next.air_tx_valid = 1'b1;
          s_next.air_tx_byte = tx_byte;
          s_next.tx_crc = rph_pkg::crc_step(s_reg.tx_crc, tx_byte);
          s_next.tx_cnt = s_reg.tx_cnt + 8'h01;
          if (s_reg.tx_cnt + 8'h01 == s_reg.tx_len) begin
            s_next.tx_state = crc_en ? rph_pkg::TX_CRC_HI : rph_pkg::TX_IDLE;
            s_next.tx_done = !crc_en;
          end
        end
      end
      rph_pkg::TX_CRC_HI: begin
        if (can_emit) begin
          s_next.air_tx_valid = 1'b1;
          s_next.air_tx_byte = s_reg.tx_crc[15:8];
          s_next.tx_state = rph_pkg::TX_CRC_LO;
        end
      end
      rph_pkg::TX_CRC_LO: begin
        if (can_emit) begin
          s_next.air_tx_valid = 1'b1;
          s_next.air_tx_byte = s_reg.tx_crc[7:0];
          s_next.tx_state = rph_pkg::TX_IDLE;
          s_next.tx_done = 1'b1;
        end
      end
      rph_pkg::TX_INF: begin
        if (len_cfg != rph_pkg::LEN_INF) begin
          s_next.tx_state = rph_pkg::TX_IDLE;
          s_next.tx_done = 1'b1;
        end else if (take) begin
          s_next.air_tx_valid = 1'b1;
          s_next.air_tx_byte = tx_byte;
        end
      end
      default: s_next.tx_state = rph_pkg::TX_IDLE;
    endcase
    // ready only when the next byte is sure to find an empty output slot
    s_next.tx_ready = !s_next.air_tx_valid && !take && (len_cfg == rph_pkg::LEN_INF ?
      s_next.tx_state == rph_pkg::TX_INF :
      (s_next.tx_state == rph_pkg::TX_LEN || s_next.tx_state == rph_pkg::TX_PAY));

    // receive deframer, buffered format only
    full = (s_reg.wr_ptr - s_reg.rd_ptr) == 7'(1 << rph_pkg::FIFO_AW);
    addr_ok = (filt_sel == rph_pkg::FILT_NONE) || (air_rx_byte == s_reg.regs.node_id) ||
      (filt_sel[1] && air_rx_byte == rph_pkg::BCAST_LOW) ||
      (filt_sel == rph_pkg::FILT_BCFF && air_rx_byte == rph_pkg::BCAST_HIGH);
    crc_new = rph_pkg::crc_step(s_reg.rx_crc, air_rx_byte);
    case (s_reg.rx_state)
      rph_pkg::RX_HUNT: begin
        if (air_rx_valid && fmt == rph_pkg::FMT_FIFO &&
            air_rx_byte == s_reg.regs.mark_hi) begin
          s_next.rx_state = rph_pkg::RX_MARK_LO;
        end
      end
      rph_pkg::RX_MARK_LO: begin
        if (air_rx_valid) begin
          s_next.pkt_start = s_reg.wr_ptr;
          s_next.rx_crc = rph_pkg::CRC_INIT;
          s_next.rx_cnt = 8'h00;
          s_next.rx_len = s_reg.regs.len_lim;
          if (air_rx_byte != s_reg.regs.mark_lo) begin
            s_next.rx_state = air_rx_byte == s_reg.regs.mark_hi ? rph_pkg::RX_MARK_LO :
              rph_pkg::RX_HUNT;
          end else if (len_cfg == rph_pkg::LEN_FIXED) begin
            s_next.rx_state = rph_pkg::RX_PAY;
          end else if (len_cfg == rph_pkg::LEN_INF) begin
            s_next.rx_state = rph_pkg::RX_INF;
          end else begin
            s_next.rx_state = rph_pkg::RX_LEN;
          end
        end
      end
      rph_pkg::RX_LEN: begin
        if (air_rx_valid) begin
          s_next.rx_crc = crc_new;
          s_next.rx_len = air_rx_byte;
          if (air_rx_byte == 8'h00 || air_rx_byte > s_reg.regs.len_lim || full) begin
            s_next.rx_state = rph_pkg::RX_HUNT;
          end else begin
            mem_we = 1'b1;
            s_next.wr_ptr = s_reg.wr_ptr + 7'h01;
            s_next.rx_state = rph_pkg::RX_PAY;
          end
        end
      end
      rph_pkg::RX_PAY: begin
        if (air_rx_valid) begin
          s_next.rx_crc = crc_new;
          s_next.rx_cnt = s_reg.rx_cnt + 8'h01;
          if (full || (s_reg.rx_cnt == 8'h00 && !addr_ok)) begin
            s_next.wr_ptr = s_reg.pkt_start;
            s_next.rx_state = rph_pkg::RX_HUNT;
          end else begin
            mem_we = 1'b1;
            s_next.wr_ptr = s_reg.wr_ptr + 7'h01;
            if (s_reg.rx_cnt + 8'h01 == s_reg.rx_len) begin
              s_next.rx_state = rph_pkg::RX_CRC_HI;
              s_next.rx_crc_ok = 1'b1;
              finish = !crc_en;
            end
          end
        end
      end
      rph_pkg::RX_CRC_HI: begin
        if (air_rx_valid) begin
          s_next.rx_crc = crc_new;
          s_next.rx_state = rph_pkg::RX_CRC_LO;
        end
      end
      rph_pkg::RX_CRC_LO: begin
        if (air_rx_valid) begin
          s_next.rx_crc_ok = crc_new == 16'h0000;
          finish = 1'b1;
        end
      end
      rph_pkg::RX_STAT_A: begin
        if (full) begin
          s_next.wr_ptr = s_reg.pkt_start;
          s_next.rx_state = rph_pkg::RX_HUNT;
        end else begin
          mem_we = 1'b1;
          mem_wdata = rssi;
          s_next.wr_ptr = s_reg.wr_ptr + 7'h01;
          s_next.rx_state = rph_pkg::RX_STAT_B;
        end
      end
      rph_pkg::RX_STAT_B: begin
        if (full) begin
          s_next.wr_ptr = s_reg.pkt_start;
        end else begin
          mem_we = 1'b1;
          mem_wdata = {s_reg.rx_crc_ok, 7'h00};
          s_next.wr_ptr = s_reg.wr_ptr + 7'h01;
          s_next.pkt_ok = s_reg.rx_crc_ok;
          s_next.pkt_bad = !s_reg.rx_crc_ok;
        end
        s_next.rx_state = rph_pkg::RX_HUNT;
      end
      rph_pkg::RX_INF: begin
        if (len_cfg != rph_pkg::LEN_INF) begin
          s_next.rx_state = rph_pkg::RX_HUNT;
        end else if (air_rx_valid && !full) begin
          mem_we = 1'b1;
          s_next.wr_ptr = s_reg.wr_ptr + 7'h01;
        end
      end
      default: s_next.rx_state = rph_pkg::RX_HUNT;
    endcase
    // end of payload or check bytes: flush, rx_status_append_enable or report
    if (finish) begin
      if (!s_next.rx_crc_ok && flush_en) begin
        s_next.wr_ptr = s_reg.pkt_start;
        s_next.pkt_bad = 1'b1;
        s_next.rx_state = rph_pkg::RX_HUNT;
      end else if (append_en) begin
        s_next.rx_state = rph_pkg::RX_STAT_A;
      end else begin
        s_next.pkt_ok = s_next.rx_crc_ok;
        s_next.pkt_bad = !s_next.rx_crc_ok;
        s_next.rx_state = rph_pkg::RX_HUNT;
      end
    end

    // host drains the receive buffer one byte per pop
    if (rx_pop && s_reg.rx_count != 7'h00) begin
      mem_re = 1'b1;
      s_next.rd_ptr = s_reg.rd_ptr + 7'h01;
    end
    s_next.rx_count = s_next.wr_ptr - s_next.rd_ptr;

    // serial paths: sync format moves one bit per strobe, async every cycle
    if (fmt == rph_pkg::FMT_ASYNC || (fmt == rph_pkg::FMT_SYNC && serial_bit_strobe)) begin
      s_next.air_serial_tx = general_pin_zero;
      s_next.general_output_pins = air_serial_rx;
    end else if (fmt == rph_pkg::FMT_FIFO) begin
      s_next.air_serial_tx = 1'b0;
      s_next.general_output_pins = 1'b0;
    end
  end

  // state register with reset values
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.regs.fifo_thr <= rph_pkg::RST_FIFO_THR;
      s_reg.regs.mark_hi <= rph_pkg::RST_MARK_HI;
      s_reg.regs.mark_lo <= rph_pkg::RST_MARK_LO;
      s_reg.regs.len_lim <= rph_pkg::RST_LEN_LIM;
      s_reg.regs.ctrl_a <= rph_pkg::RST_CTRL_A;
      s_reg.regs.ctrl_b <= rph_pkg::RST_CTRL_B;
      s_reg.regs.node_id <= rph_pkg::RST_NODE_ID;
      s_reg.tx_state <= rph_pkg::TX_IDLE;
      s_reg.rx_state <= rph_pkg::RX_HUNT;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = s_reg.reg_rdata;
  assign tx_ready = s_reg.tx_ready;
  assign tx_done = s_reg.tx_done;
  assign air_tx_byte = s_reg.air_tx_byte;
  assign air_tx_valid = s_reg.air_tx_valid;
  assign rx_count = s_reg.rx_count;
  assign pkt_ok = s_reg.pkt_ok;
  assign pkt_bad = s_reg.pkt_bad;
  assign air_serial_tx = s_reg.air_serial_tx;
  assign general_output_pins = s_reg.general_output_pins;
endmodule // rph_packet_handler

//--- sim/rph_air_model.sv
// air-side partner: byte sink with random stalls and a frame source
`timescale 1ns/10ps
module rph_air_model (
  input wire logic core_clk,
  input wire logic [7:0] air_tx_byte,
  input wire logic air_tx_valid,
  output logic air_tx_ready,
  output logic [7:0] air_rx_byte,
  output logic air_rx_valid
);
  logic [7:0] got[$];
  initial begin
    air_tx_ready = 1'b1;
    air_rx_valid = 1'b0;
    air_rx_byte = 8'h00;
  end
  // keep every byte the modulator takes
  always @(posedge core_clk) begin
    if (air_tx_valid && air_tx_ready) got.push_back(air_tx_byte);
  end
  // accept promptly three times in four, otherwise stall
  always @(negedge core_clk) begin
    air_tx_ready <= ($urandom_range(3) != 0);
  end
  // one byte per cycle, then the line shows the inverse of the last byte
  task send(input logic [7:0] s[$]);
    foreach (s[i]) begin
      @(negedge core_clk);
      air_rx_byte = s[i];
      air_rx_valid = 1'b1;
    end
    @(negedge core_clk);
    air_rx_valid = 1'b0;
    air_rx_byte = ~s[s.size()-1];
  endtask
endmodule // rph_air_model

//--- sim/rph_packet_handler_chk.sv
// port-level assertions for the packet handler
`timescale 1ns/10ps
module rph_packet_handler_chk (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [5:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic tx_ready,
  input wire logic tx_done,
  input wire logic [7:0] air_tx_byte,
  input wire logic air_tx_valid,
  input wire logic air_tx_ready,
  input wire logic [6:0] rx_count,
  input wire logic pkt_ok,
  input wire logic pkt_bad
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // read data only moves on a read
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  // unmapped offsets read zero
  unmapped_zero_a: assert property (reg_rd && (reg_addr < rph_pkg::OFS_FIFO_THR ||
    reg_addr > rph_pkg::OFS_NODE_ID) |=> reg_rdata == 8'h00)
    else $error("unmapped offset read nonzero");
  // unused bits of both control registers read zero
  ctrl_a_unused_a: assert property (reg_rd && reg_addr == rph_pkg::OFS_CTRL_A
    |=> !reg_rdata[4])
    else $error("control a bit 4 set");
  ctrl_b_unused_a: assert property (reg_rd && reg_addr == rph_pkg::OFS_CTRL_B
    |=> reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0)
    else $error("control b unused bit set");
  // packet end strobes last one cycle
  done_pulse_a: assert property (tx_done |=> !tx_done)
    else $error("transmit done longer than a cycle");
  rx_end_pulse_a: assert property (pkt_ok || pkt_bad |=> !pkt_ok && !pkt_bad)
    else $error("receive end strobe longer than a cycle");
  ok_bad_excl_a: assert property (!(pkt_ok && pkt_bad))
    else $error("good and bad together");
  // air byte holds until taken
  air_hold_a: assert property (air_tx_valid && !air_tx_ready
    |=> air_tx_valid && $stable(air_tx_byte))
    else $error("air byte dropped before taken");
  slot_ready_a: assert property (tx_ready |-> !air_tx_valid)
    else $error("ready while air slot full");
  count_max_a: assert property (rx_count <= 7'h40)
    else $error("receive count above capacity");
  cover property (pkt_ok);
  cover property (pkt_bad);
  cover property (tx_done);
  cover property (air_tx_valid && !air_tx_ready);
endmodule // rph_packet_handler_chk

//--- sim/tb_rph_packet_handler.sv
// self-checking bench for the packet handler
`timescale 1ns/10ps
module tb_rph_packet_handler;
  logic core_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, tx_valid = 0, rx_pop = 0;
  logic general_pin_zero = 0, air_serial_rx = 0, serial_bit_strobe = 0;
  logic [5:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, tx_byte = 0, rssi = 0, reg_rdata, rx_data, air_tx_byte, air_rx_byte;
  logic tx_ready, tx_done, air_tx_valid, air_tx_ready, air_rx_valid, pkt_ok, pkt_bad;
  logic air_serial_tx, general_output_pins;
  logic [6:0] rx_count;
  int miscompares = 0, n_compared = 0, ok_n = 0, bad_n = 0, done_n = 0;
  logic [7:0] mh, ml, d, w, q[$];
  logic [7:0] rv[11] = '{8'h00, 8'h00, 8'h00, 8'h07, 8'hD3, 8'h91, 8'hFF, 8'h04, 8'h45,
    8'h00, 8'h00};
  logic [7:0] ads[4] = '{8'h5A, 8'h00, 8'hFF, 8'h33};
  rph_packet_handler u_dut (.core_clk, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .tx_byte, .tx_valid, .tx_ready, .tx_done, .air_tx_byte, .air_tx_valid,
    .air_tx_ready, .air_rx_byte, .air_rx_valid, .rssi, .rx_pop, .rx_data, .rx_count, .pkt_ok,
    .pkt_bad, .general_pin_zero, .air_serial_rx, .serial_bit_strobe, .air_serial_tx,
    .general_output_pins);
  rph_air_model u_air (.core_clk, .air_tx_byte, .air_tx_valid, .air_tx_ready, .air_rx_byte,
    .air_rx_valid);
  always #25 core_clk = ~core_clk;
  // count end strobes
  always @(posedge core_clk) begin
    ok_n += pkt_ok;
    bad_n += pkt_bad;
    done_n += tx_done;
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task stall_out;
    miscompares++;
    $display("mismatch at %0t: wait ran out", $time);
    finish_test;
  endtask
  task wr(input logic [5:0] a, input logic [7:0] v);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1;
    @(negedge core_clk);
    reg_wr = 0;
  endtask
  task rd(input logic [5:0] a);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge core_clk);
    reg_rd = 0;
    d = reg_rdata;
  endtask
  // check sequence over a byte list, msb first
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c = 16'hFFFF;
    foreach (b[i]) for (int k = 7; k >= 0; k--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i][k]) ?
      16'h8005 : 16'h0000);
    return c;
  endfunction
  function automatic logic [7:0] msk(input int a);
    return a == 7 ? 8'hEF : a == 8 ? 8'h77 : (a >= 3 && a <= 9) ? 8'hFF : 8'h00;
  endfunction
  // hand q to the transmitter and compare what reaches the air
  task tx_pkt(input bit crc_on, input bit inf = 0);
    logic [7:0] ex[$];
    logic [15:0] c;
    int i, dn;
    u_air.got.delete();
    dn = done_n;
    @(negedge core_clk);
    foreach (q[j]) begin
      tx_byte = q[j];
      tx_valid = 1;
      for (i = 0; i < 300 && tx_ready !== 1'b1; i++) @(negedge core_clk);
      if (i == 300) stall_out;
      @(negedge core_clk);
    end
    tx_valid = 0;
    if (inf) wr(8, 8'h40);
    for (i = 0; i < 300 && (done_n == dn || air_tx_valid !== 1'b0); i++) @(negedge core_clk);
    if (i == 300) stall_out;
    c = crc16(q);
    ex = {mh, ml, q};
    if (crc_on) ex = {ex, c[15:8], c[7:0]};
    chk(8'(u_air.got.size()), 8'(ex.size()));
    foreach (ex[j]) chk(u_air.got[j], ex[j]);
    chk(8'(done_n - dn), 8'h01);
  endtask
  // one frame over the air; the buffer is emptied before the next one
  task rx_frame(input logic [7:0] f[$], input int ok_e, input int bad_e, input bit keep);
    logic [7:0] ex[$];
    logic [15:0] c;
    int o, b;
    o = ok_n;
    b = bad_n;
    c = crc16(f);
    u_air.send({mh, ml, f, c[15:8], c[7:0] ^ 8'(bad_e)});
    repeat (40) @(negedge core_clk);
    chk(8'(ok_n - o), 8'(ok_e));
    chk(8'(bad_n - b), 8'(bad_e));
    ex = {};
    if (keep) ex = {f, rssi, 8'h80};
    chk({1'b0, rx_count}, 8'(ex.size()));
    foreach (ex[j]) begin
      @(negedge core_clk);
      rx_pop = 1;
      @(negedge core_clk);
      rx_pop = 0;
      chk(rx_data, ex[j]);
    end
  endtask
  initial begin
    void'($urandom(35396));
    mh = 8'hD3;
    ml = 8'h91;
    repeat (2) @(negedge core_clk);
    srst = 0;
    for (int a = 2; a <= 10; a++) begin
      rd(a);
      chk(d, rv[a]);
    end
    $display("test reset values done");
    for (int a = 2; a <= 10; a++) begin
      w = $urandom;
      if (a == 6) w[0] = 1'b1;
      wr(a, w);
      rd(a);
      chk(d, w & msk(a));
    end
    $display("test register access done");
    mh = $urandom;
    ml = $urandom;
    wr(4, mh);
    wr(5, ml);
    wr(6, 8'h04);
    wr(7, 8'h04);
    wr(8, 8'h45);
    wr(9, 8'h5A);
    q = {8'h02, 8'($urandom), 8'($urandom)};
    tx_pkt(1);
    wr(8, 8'h40);
    q = {8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)};
    tx_pkt(0);
    wr(8, 8'h42);
    q = {8'($urandom), 8'($urandom), 8'($urandom)};
    tx_pkt(0, 1);
    $display("test transmit done");
    wr(8, 8'h45);
    for (int f = 0; f < 4; f++) begin
      wr(7, 8'h04 | 8'(f));
      foreach (ads[k]) begin
        w = ads[k];
        d = 8'(f == 0 || w == 8'h5A || (f >= 2 && w == 8'h00) || (f == 3 && w == 8'hFF));
        rssi = $urandom;
        rx_frame({8'h02, w, 8'($urandom)}, d, 0, d[0]);
      end
    end
    rx_frame({8'h05, 8'h5A, 8'h11, 8'h22, 8'h33, 8'h44}, 0, 0, 0);
    wr(7, 8'h0C);
    rx_frame({8'h01, 8'h5A}, 0, 1, 0);
    $display("test receive done");
    for (int m = 0; m < 2; m++) begin
      @(negedge core_clk);
      general_pin_zero = 0;
      air_serial_rx = 0;
      serial_bit_strobe = 0;
      wr(8, m == 0 ? 8'h75 : 8'h55);
      d = 8'h00;
      repeat (20) begin
        @(negedge core_clk);
        chk({6'h00, air_serial_tx, general_output_pins}, d);
        general_pin_zero = $urandom;
        air_serial_rx = $urandom;
        serial_bit_strobe = $urandom;
        if (m == 0 || serial_bit_strobe) d = {6'h00, general_pin_zero, air_serial_rx};
      end
    end
    $display("test serial paths done");
    finish_test;
  end
endmodule // tb_rph_packet_handler
bind rph_packet_handler rph_packet_handler_chk u_chk (.core_clk, .srst, .reg_addr, .reg_rd,
  .reg_rdata, .tx_ready, .tx_done, .air_tx_byte, .air_tx_valid, .air_tx_ready, .rx_count,
  .pkt_ok, .pkt_bad);
